// ### include/iom_pkg.sv
// Package of constants and types for the reply-list messaging block
package iom_pkg;

  // ------------------------------------------------------------------
  // Message image map
  // ------------------------------------------------------------------
  localparam logic [11:0] IOM_OFS_IRQ_STATUS = 12'h030;
  localparam logic [11:0] IOM_OFS_IRQ_MASK   = 12'h034;
  localparam logic [11:0] IOM_OFS_IN_QUEUE   = 12'h040;
  localparam logic [11:0] IOM_OFS_OUT_QUEUE  = 12'h044;
  localparam int          IOM_SHELL_BITS     = 12;
  localparam int          IOM_SR_BIT         = 3;
  localparam logic [31:0] IOM_RESET_WORD     = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Controller register map (AHB-Lite byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] IOM_CR_CTRL      = 8'h00;
  localparam logic [7:0] IOM_CR_HOST_OFS  = 8'h04;
  localparam logic [7:0] IOM_CR_IOP_INDEX = 8'h08;
  localparam logic [7:0] IOM_CR_INC       = 8'h0C;
  localparam logic [7:0] IOM_CR_FREE_TOP  = 8'h10;
  localparam logic [7:0] IOM_CR_POST_BOT  = 8'h14;
  localparam logic [7:0] IOM_CR_STATUS    = 8'h18;
  localparam logic [7:0] IOM_CR_LIST_BASE = 8'h1C;
  localparam logic [7:0] IOM_CR_HOST_IDX  = 8'h20;
  localparam logic [7:0] IOM_CR_POST_PUSH = 8'h24;
  localparam logic [31:0] IOM_INDEX_STEP  = 32'h0000_0004;

  // Control word fields
  localparam int IOM_CTL_UNIT_EN = 0;
  localparam int IOM_CTL_EXT_EN  = 1;
  localparam int IOM_CTL_SIZE_LO = 4;
  localparam int IOM_SIZE_W      = 4;

  // ------------------------------------------------------------------
  // Host-side access from the PCI face
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [11:0] ofs;
    logic [31:0] wdata;
  } iom_host_req_t;

  typedef enum logic [1:0] {
    IOM_ST_IDLE,
    IOM_ST_DATA
  } iom_bus_state_t;

endpackage

// ### include/iom_if.sv
// Interface joining host PCI face and the messaging device
`timescale 1ns/100ps
interface iom_if;
  import iom_pkg::*;
  logic        acc_req;
  logic        acc_wr;
  logic [11:0] acc_ofs;
  logic [31:0] acc_wdata;
  logic        acc_ack;
  logic        acc_hit;
  logic [31:0] acc_rdata;
  logic        host_irq;

  modport device (
    input  acc_req, acc_wr, acc_ofs, acc_wdata,
    output acc_ack, acc_hit, acc_rdata, host_irq
  );
  modport host (
    output acc_req, acc_wr, acc_ofs, acc_wdata,
    input  acc_ack, acc_hit, acc_rdata, host_irq
  );
endinterface

// ### rtl/iom_host_end.sv
// Host end: turns user requests into image accesses and waits on them
`timescale 1ns/100ps
module iom_host_end (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Image link
  iom_if.host              lnk,
  // User side
  input  wire logic        usr_req,
  input  wire logic        usr_wr,
  input  wire logic [11:0] usr_ofs,
  input  wire logic [31:0] usr_wdata,
  output      logic        usr_busy,
  output      logic        usr_done,
  output      logic        usr_hit,
  output      logic [31:0] usr_rdata,
  output      logic        usr_irq
);
  import iom_pkg::*;

  typedef struct packed {
    iom_host_req_t r;
    logic          done;
    logic          hit;
    logic [31:0]   rdata;
    logic          irq_m;
    logic          irq;
  } iom_host_st_t;

  iom_host_st_t st_q, st_d;

  // ------------------------------------------------------------------
  // Request holding and reply capture
  // ------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.done  = 1'b0;
    st_d.irq_m = lnk.host_irq;
    st_d.irq   = st_q.irq_m;
    if (st_q.r.req && lnk.acc_ack) begin
      st_d.r.req = 1'b0;
      st_d.done  = 1'b1;
      st_d.hit   = lnk.acc_hit;
      st_d.rdata = st_q.r.wr ? st_q.rdata : lnk.acc_rdata;
    end else if (!st_q.r.req && usr_req) begin
      st_d.r.req = 1'b1;
      st_d.r.wr  = usr_wr;
      st_d.r.ofs = usr_ofs;
      // Returned frames carry the cycle bit cleared
      st_d.r.wdata = (usr_wr && usr_ofs == IOM_OFS_OUT_QUEUE) ?
                     {usr_wdata[31:1], 1'b0} : usr_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk.acc_req   = st_q.r.req;
  assign lnk.acc_wr    = st_q.r.wr;
  assign lnk.acc_ofs   = st_q.r.ofs;
  assign lnk.acc_wdata = st_q.r.wdata;
  assign usr_busy      = st_q.r.req;
  assign usr_done      = st_q.done;
  assign usr_hit       = st_q.hit;
  assign usr_rdata     = st_q.rdata;
  assign usr_irq       = st_q.irq;
endmodule

// ### rtl/iom_dev_end.sv
// Device end: reply-list index tracking, shell decode and AHB-Lite slave
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module iom_dev_end (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Image link
  iom_if.device            lnk,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata
);
  import iom_pkg::*;

  typedef struct packed {
    logic                  unit_en;
    logic                  ext_en;
    logic [IOM_SIZE_W-1:0] list_size;
    logic [11:0]           host_ofs;
    logic [31:0]           list_base;
    logic [31:0]           iop_index;
    logic [31:0]           host_index;
    logic                  mask;
    logic                  service;
    logic [31:0]           free_top;
    logic [31:0]           post_bot;
    logic [31:0]           post_word;
    logic                  post_valid;
    logic                  ret_toggle;
    iom_bus_state_t        bst;
    logic                  bwr;
    logic [7:0]            baddr;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  hit;
    logic [31:0]           lrdata;
  } iom_dev_st_t;

  iom_dev_st_t st_q, st_d;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  logic [31:0] size_mask;
  logic [31:0] aligned_host;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_queue;
  logic        hit_hidx;

  // Host index written through the image kept inside a naturally aligned list window
  assign size_mask = (32'h0000_0010 << st_q.list_size) - 32'h0000_0001;
  assign aligned_host = (st_q.list_base & ~size_mask) |
                        (lnk.acc_wdata & size_mask & ~32'h0000_0003);

  // Image offsets are 12 bits wide, so every shell access lies below
  // 4 Kbytes and frame space above that point never reaches this decode
  assign hit_status = st_q.unit_en &&
                      lnk.acc_ofs == IOM_OFS_IRQ_STATUS;
  assign hit_mask   = st_q.unit_en &&
                      lnk.acc_ofs == IOM_OFS_IRQ_MASK;
  assign hit_queue  = st_q.unit_en &&
                      lnk.acc_ofs == IOM_OFS_OUT_QUEUE;
  // Host index offset is a 12-bit field, held inside the shell
  assign hit_hidx   = st_q.unit_en &&
                      lnk.acc_ofs == st_q.host_ofs;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.ack    = 1'b0;
    // Non-empty while unit_en and ext_en are both set and the two indices differ
    st_d.service = st_q.unit_en && st_q.ext_en &&
                   (st_q.host_index != st_q.iop_index);

    // Host accesses through the image
    if (lnk.acc_req && !st_q.ack) begin
      st_d.ack    = 1'b1;
      st_d.hit    = hit_status | hit_mask | hit_queue | hit_hidx;
      st_d.lrdata = IOM_RESET_WORD;
      if (hit_status) begin
        st_d.lrdata[IOM_SR_BIT] = st_q.service;
      end else if (hit_mask) begin
        // Only the mask bit is stored; all other bits read as zero
        st_d.lrdata[IOM_SR_BIT] = st_q.mask;
        if (lnk.acc_wr) begin
          st_d.mask = lnk.acc_wdata[IOM_SR_BIT];
        end
      end else if (hit_queue) begin
        if (lnk.acc_wr) begin
          // Returned frame goes to the free list like any other
          st_d.free_top   = lnk.acc_wdata;
          st_d.ret_toggle = ~st_q.ret_toggle;
        end else begin
          st_d.lrdata     = st_q.post_valid ? st_q.post_word : '0;
          st_d.post_valid = 1'b0;
          // Pop moves the bottom even when a push lands in this cycle
          if (st_q.post_valid) begin
            st_d.post_bot = st_q.post_bot + IOM_INDEX_STEP;
          end
        end
      end else if (hit_hidx) begin
        st_d.lrdata = st_q.host_index;
        if (lnk.acc_wr) begin
          st_d.host_index = aligned_host;
        end
      end
    end

    // AHB-Lite slave: address phase then single-cycle data phase; read
    // data is fetched at the address phase, so no wait state is needed
    st_d.bst = IOM_ST_IDLE;
    if (st_q.bst == IOM_ST_DATA) begin
      if (st_q.bwr) begin
        unique case (st_q.baddr)
          IOM_CR_CTRL: begin
            st_d.unit_en   = hwdata[IOM_CTL_UNIT_EN];
            st_d.ext_en    = hwdata[IOM_CTL_EXT_EN];
            st_d.list_size =
              hwdata[IOM_CTL_SIZE_LO +: IOM_SIZE_W];
          end
          IOM_CR_HOST_OFS:  st_d.host_ofs   = {hwdata[11:2], 2'b00};
          IOM_CR_IOP_INDEX: st_d.iop_index  = hwdata;
          IOM_CR_INC:       st_d.iop_index  = st_q.iop_index +
                                              IOM_INDEX_STEP;
          IOM_CR_LIST_BASE: st_d.list_base  = hwdata;
          IOM_CR_HOST_IDX:  st_d.host_index = hwdata;
          IOM_CR_POST_PUSH: begin
            st_d.post_word  = hwdata;
            st_d.post_valid = 1'b1;
          end
          default: ;
        endcase
      end
    end
    if (hsel && hready && htrans[1]) begin
      st_d.bst   = IOM_ST_DATA;
      st_d.bwr   = hwrite;
      st_d.baddr = haddr[7:0];
      unique case (haddr[7:0])
        IOM_CR_CTRL: st_d.rdata = {24'h00_0000,
                                   st_q.list_size, 2'b00,
                                   st_q.ext_en, st_q.unit_en};
        IOM_CR_HOST_OFS:  st_d.rdata = {20'h0_0000, st_q.host_ofs};
        IOM_CR_IOP_INDEX: st_d.rdata = st_q.iop_index;
        IOM_CR_FREE_TOP:  st_d.rdata = st_q.free_top;
        IOM_CR_POST_BOT:  st_d.rdata = st_q.post_bot;
        IOM_CR_STATUS:    st_d.rdata = {29'h0000_0000, st_q.ret_toggle,
                                        st_q.post_valid, st_q.service};
        IOM_CR_LIST_BASE: st_d.rdata = st_q.list_base;
        IOM_CR_HOST_IDX:  st_d.rdata = st_q.host_index;
        default:          st_d.rdata = IOM_RESET_WORD;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign lnk.acc_ack   = st_q.ack;
  assign lnk.acc_hit   = st_q.hit;
  assign lnk.acc_rdata = st_q.lrdata;
  assign lnk.host_irq  = st_q.service && !st_q.mask;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = st_q.rdata;
endmodule

// ### dv/iom_monitor.sv
// Checker on the image link between the host and device ends
`timescale 1ns/100ps
module iom_monitor
  import iom_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Image link
  input wire logic        acc_req,
  input wire logic        acc_wr,
  input wire logic [11:0] acc_ofs,
  input wire logic [31:0] acc_wdata,
  input wire logic        acc_ack,
  input wire logic        acc_hit,
  input wire logic [31:0] acc_rdata,
  input wire logic        host_irq
);
  logic msk_q;
  logic msk_now;
  logic rd_ok;
  localparam logic [31:0] RSV = ~(32'h1 << IOM_SR_BIT);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mask as last written by the host
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) msk_q <= 1'b0;
    else if (acc_ack && acc_hit && acc_wr && acc_ofs == IOM_OFS_IRQ_MASK)
      msk_q <= acc_wdata[IOM_SR_BIT];
  end
  assign rd_ok = acc_ack && acc_hit && !acc_wr;
  // The device applies a mask write in the same cycle its answer shows
  assign msk_now = (acc_ack && acc_hit && acc_wr &&
                    acc_ofs == IOM_OFS_IRQ_MASK) ?
                   acc_wdata[IOM_SR_BIT] : msk_q;
  chk_ack_next: assert property (acc_req && !acc_ack |=> acc_ack)
    else $error("link answer not one cycle after request");
  chk_ack_pulse: assert property (acc_ack |=> !acc_ack)
    else $error("link answer longer than one cycle");
  chk_ack_cause: assert property (!acc_req |=> !acc_ack)
    else $error("link answer without request");
  chk_req_held: assert property (acc_req && !acc_ack |=>
    acc_req && $stable(acc_ofs) && $stable(acc_wr))
    else $error("request changed before answer");
  chk_req_drop: assert property (acc_ack |=> !acc_req)
    else $error("request kept after answer");
  chk_stat_resv: assert property (
    rd_ok && acc_ofs == IOM_OFS_IRQ_STATUS |-> (acc_rdata & RSV) == 32'h0)
    else $error("status reserved bits set");
  chk_mask_resv: assert property (
    rd_ok && acc_ofs == IOM_OFS_IRQ_MASK |-> (acc_rdata & RSV) == 32'h0)
    else $error("mask reserved bits set");
  chk_miss_zero: assert property (
    acc_ack && !acc_hit |-> acc_rdata == 32'h0)
    else $error("unclaimed access returned data");
  chk_irq_masked: assert property (
    msk_now |-> !host_irq)
    else $error("interrupt raised while masked");
endmodule

// ### dv/iom_test.sv
// Self-checking bench joining both ends of the messaging link
`timescale 1ns/100ps
module iom_test;
  import iom_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        usr_req, usr_wr, usr_busy, usr_done, usr_hit, usr_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] usr_ofs;
  logic [31:0] haddr, hwdata, hrdata, usr_wdata, usr_rdata, exa, q;
  logic [31:0] ahq[$];
  logic        rd_ph;
  logic [33:0] exq[$];
  logic [33:0] ex;
  int          errors, n_compared, seed;
  localparam logic [31:0] SRM = 32'h1 << IOM_SR_BIT;
  iom_if lnk ();
  iom_dev_end u_iom_dev_end (.hclk(hclk), .hresetn(hresetn), .lnk(lnk),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  iom_host_end u_iom_host_end (.hclk(hclk), .hresetn(hresetn), .lnk(lnk),
    .usr_req(usr_req), .usr_wr(usr_wr), .usr_ofs(usr_ofs),
    .usr_wdata(usr_wdata), .usr_busy(usr_busy), .usr_done(usr_done),
    .usr_hit(usr_hit), .usr_rdata(usr_rdata), .usr_irq(usr_irq));
  iom_monitor u_iom_monitor (.hclk(hclk), .hresetn(hresetn),
    .acc_req(lnk.acc_req), .acc_wr(lnk.acc_wr), .acc_ofs(lnk.acc_ofs),
    .acc_wdata(lnk.acc_wdata), .acc_ack(lnk.acc_ack),
    .acc_hit(lnk.acc_hit), .acc_rdata(lnk.acc_rdata),
    .host_irq(lnk.host_irq));
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One single-word AHB-Lite transfer
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  // One AHB-Lite read; the expected word is noted for the read watcher
  task automatic ahbr(input logic [7:0] a, input logic [31:0] e);
    ahq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  // One image access from the user side; expected {hit, data} queued
  task automatic ua(input logic w, input logic [11:0] o,
                    input logic [31:0] d, input logic [32:0] e);
    exq.push_back({w, e});
    @(posedge hclk);
    usr_req <= 1'b1;
    usr_wr <= w;
    usr_ofs <= o;
    usr_wdata <= d;
    @(posedge hclk);
    usr_req <= 1'b0;
    do @(posedge hclk); while (usr_done !== 1'b1);
  endtask
  always @(posedge hclk) begin
    if (usr_done === 1'b1) begin
      ex = exq.pop_front();
      check({usr_hit, ex[33] ? 32'h0 : usr_rdata},
            {ex[32], ex[33] ? 32'h0 : ex[31:0]});
      check({usr_busy, hresp}, 2'b00);
    end
  end
  // AHB-Lite read data is taken at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      exa = ahq.pop_front();
      check(hrdata, exa);
    end
    if (hreadyout === 1'b1) begin
      rd_ph <= htrans[1] && !hwrite;
    end
  end
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_sim();
  end
  initial begin
    {hresetn, hwrite, usr_req, usr_wr, htrans} = '0;
    {haddr, hwdata, usr_ofs, usr_wdata} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    errors = 0;
    n_compared = 0;
    seed = 52;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ua(0, IOM_OFS_IRQ_STATUS, 0, 33'h0);
    ua(1, IOM_OFS_IRQ_MASK, 32'hF, 33'h0);
    ahb(1, IOM_CR_CTRL, 32'h1);
    ua(0, IOM_OFS_IRQ_MASK, 0, {1'b1, 32'h0});
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
    repeat (4) begin
      q = $random(seed);
      ua(1, IOM_OFS_IRQ_MASK, q, {1'b1, 32'h0});
      ua(0, IOM_OFS_IRQ_MASK, 0, {1'b1, q & SRM});
    end
    ua(1, IOM_OFS_IRQ_MASK, 0, {1'b1, 32'h0});
    ahb(1, IOM_CR_LIST_BASE, 32'h1000);
    ahb(1, IOM_CR_HOST_IDX, 32'h1000);
    ahb(1, IOM_CR_IOP_INDEX, 32'h1000);
    ahb(1, IOM_CR_HOST_OFS, 32'h80);
    ahb(1, IOM_CR_INC, 32'h0);
    ahbr(IOM_CR_IOP_INDEX, 32'h1004);
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
    ahb(1, IOM_CR_CTRL, 32'h3);
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, SRM});
    check(usr_irq, 1);
    ua(1, IOM_OFS_IRQ_MASK, SRM, {1'b1, 32'h0});
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, SRM});
    check(usr_irq, 0);
    ua(1, IOM_OFS_IRQ_MASK, 0, {1'b1, 32'h0});
    ua(1, 12'h080, 32'h5004, {1'b1, 32'h0});
    ahbr(IOM_CR_HOST_IDX, 32'h1004);
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
    check(usr_irq, 0);
    // IOP index written back to the list base: the list is non-empty again
    ahb(1, IOM_CR_IOP_INDEX, 32'h1000);
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, SRM});
    ua(1, 12'h080, 32'h1000, {1'b1, 32'h0});
    ua(0, 12'h080, 0, {1'b1, 32'h1000});
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
    q = $random(seed) | 32'h1;
    ahb(1, IOM_CR_POST_PUSH, q);
    ua(0, IOM_OFS_OUT_QUEUE, 0, {1'b1, q});
    ahbr(IOM_CR_POST_BOT, 32'h4);
    ua(1, IOM_OFS_OUT_QUEUE, q, {1'b1, 32'h0});
    ahbr(IOM_CR_FREE_TOP, q & 32'hFFFF_FFFE);
    ahbr(8'h40, 32'h0);
    // Port reset in mid-run brings mask and indices back to zero
    ua(1, IOM_OFS_IRQ_MASK, SRM, {1'b1, 32'h0});
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1, IOM_CR_CTRL, 32'h3);
    ua(0, IOM_OFS_IRQ_MASK, 0, {1'b1, 32'h0});
    ua(0, IOM_OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
    ahbr(IOM_CR_HOST_IDX, 32'h0);
    ahb(1, IOM_CR_CTRL, 32'h0);
    ua(0, IOM_OFS_IRQ_STATUS, 0, 33'h0);
    end_sim();
  end
endmodule
